// ==== rtl/busbar_pkg.sv ====
/*
 Package for the busbar module register: word width, print-cycle timing,
 selection timing periods, the carrier struct for strobes and the print-state enum.
 Assumes a single 20 MHz system clock.
*/
package busbar_pkg;

	// ****************************************
	// Word and timing
	// ****************************************
	localparam int WORD_BITS       = 18;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int PRINT_TIME_MS   = 100;
	localparam int PRINT_CYCLES    = (PRINT_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int PERIOD_BITS     = 3;
	localparam logic [PERIOD_BITS-1:0] PERIOD_UNPICK_A = 3'h0;
	localparam logic [PERIOD_BITS-1:0] PERIOD_UNPICK_B = 3'h1;
	localparam logic [PERIOD_BITS-1:0] PERIOD_SELECT   = 3'h3;
	localparam logic [PERIOD_BITS-1:0] PERIOD_XFER_A   = 3'h4;
	localparam logic [PERIOD_BITS-1:0] PERIOD_XFER_B   = 3'h5;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic                   out_reg_clear;
		logic                   out_reg_load_strobe;
		logic                   out_gate_strobe;
		logic                   device_unpick_strobe;
		logic                   device_pick_strobe;
		logic [PERIOD_BITS-1:0] period;
	} strobes_t;

	typedef enum logic [1:0] {
		PR_IDLE = 2'b01,
		PR_BUSY = 2'b10
	} print_state_t;

endpackage

// ==== rtl/busbar_drive.sv ====
/*
 Inverting busbar-drive buffer: forwards the active-low output busbars onto
 the active-high input busbars that feed every module's data inputs.
 Assumes the output busbars are a wired-OR of module drivers resolved outside.
*/
module busbar_drive #(
	parameter int WIDTH = 18
) (
	input  wire logic [WIDTH-1:0] i_bus_out_n,
	output logic      [WIDTH-1:0] o_bus_in
);
	// ****************************************
	// Inversion per line
	// ****************************************
	assign o_bus_in = ~i_bus_out_n;
endmodule

// ==== rtl/busbar_module_register.sv ====
/*
 Printer-drive operational module: an N-bit register loaded from the input
 busbars under strobes, presented on the output busbars, with device
 selection and a busy flag covering the print cycle.
 Assumes strobes are one clock wide or longer and synchronous to i_sys_clk;
 output busbars are active low, resolved (wired) outside this module.
*/
// Summary of operation
// - A clear pulse forces every bit of the register to zero.
// - While the load strobe is active, bits whose input busbar is one are set.
// - With the load strobe inactive, busbar changes do not touch the register.
// - While the output gate is active, the stored word drives the output busbars.
// - Words move in parallel, one busbar line per register bit.
// - The drive buffer forwards output busbars onto the input busbars.
// - The drive buffer inverts each line, active-low out to active-high in.
// - After a character is loaded, busy stands for the whole print cycle.
// - While busy, busbar traffic does not disturb the held register.
// - The selection memory is cleared in periods 0 and 1 and set in period 3 on address match.
// - Only a selected device accepts clear and load, in periods 4 and 5.
module busbar_module_register
	import busbar_pkg::*;
#(
	parameter int WIDTH        = busbar_pkg::WORD_BITS,
	parameter int PRINT_COUNT  = busbar_pkg::PRINT_CYCLES,
	parameter logic [WORD_BITS-1:0] DEVICE_ADDR = 18'h00003
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_rst_n,
	input  wire busbar_pkg::strobes_t       i_strobes,
	input  wire logic [WIDTH-1:0]           i_bus_out_n,
	output logic      [WIDTH-1:0]           o_bus_in,
	output logic      [WIDTH-1:0]           o_drive_n,
	output logic                            o_selected,
	output logic                            o_busy,
	output logic                            o_print_start,
	output logic      [WIDTH-1:0]           o_char
);
	import busbar_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (WIDTH < 1 || WIDTH > WORD_BITS)
		$error("WIDTH must lie in 1..18");
	if (PRINT_COUNT < 2)
		$error("PRINT_COUNT must be at least 2");

	localparam int CNT_W = $clog2(PRINT_COUNT + 1);

	// ****************************************
	// Busbar drive
	// ****************************************
	logic [WIDTH-1:0] bus_in;

	busbar_drive #(.WIDTH(WIDTH)) u_drive (
		.i_bus_out_n (i_bus_out_n),
		.o_bus_in    (bus_in)
	);
	assign o_bus_in = bus_in;

	// ****************************************
	// Selection memory
	// ****************************************
	logic selected;
	logic next_selected;
	logic addr_match;
	logic in_unpick;
	logic in_xfer;

	assign addr_match = (bus_in == DEVICE_ADDR[WIDTH-1:0]);
	assign in_unpick  = (i_strobes.period == PERIOD_UNPICK_A) || (i_strobes.period == PERIOD_UNPICK_B);
	assign in_xfer    = (i_strobes.period == PERIOD_XFER_A) || (i_strobes.period == PERIOD_XFER_B);

	always_comb
	begin
		next_selected = selected;
		if (i_strobes.device_unpick_strobe && in_unpick)
			next_selected = 1'b0;
		else if (i_strobes.device_pick_strobe && i_strobes.period == PERIOD_SELECT && addr_match)
			next_selected = 1'b1;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			selected <= 1'b0;
		else
			selected <= next_selected;
	end

	// ****************************************
	// Module register
	// ****************************************
	logic [WIDTH-1:0] word;
	logic [WIDTH-1:0] next_word;
	logic             do_clear;
	logic             do_load;

	// Clear and load gated by selection so a shared strobe touches only this device;
	// both are refused while busy so the character being printed cannot be lost
	assign do_clear = i_strobes.out_reg_clear && selected && in_xfer && !o_busy;
	assign do_load  = i_strobes.out_reg_load_strobe && selected && in_xfer && !o_busy;

	always_comb
	begin
		next_word = word;
		if (do_clear)
			next_word = '0;
		else if (do_load)
			next_word = word | bus_in;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			word <= '0;
		else
			word <= next_word;
	end

	assign o_char = word;
	// Active-low drive: a one pulls its line low only while gated
	assign o_drive_n = i_strobes.out_gate_strobe ? ~word : '1;

	// ****************************************
	// Print cycle
	// ****************************************
	print_state_t     pstate;
	print_state_t     next_pstate;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             load_seen;
	logic             next_load_seen;
	logic             start;

	// Print starts when the load strobe falls, so the word is complete
	assign start = load_seen && !do_load;

	always_comb
	begin
		next_pstate    = pstate;
		next_cnt       = cnt;
		next_load_seen = do_load;
		case (pstate)
			PR_IDLE:
			begin
				if (start)
				begin
					next_pstate = PR_BUSY;
					next_cnt    = CNT_W'(PRINT_COUNT - 1);
				end
			end
			PR_BUSY:
			begin
				if (cnt == '0)
					next_pstate = PR_IDLE;
				else
					next_cnt = cnt - 1'b1;
			end
			default:
			begin
				next_pstate = PR_IDLE;
				next_cnt    = '0;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pstate    <= PR_IDLE;
			cnt       <= '0;
			load_seen <= 1'b0;
		end
		else
		begin
			pstate    <= next_pstate;
			cnt       <= next_cnt;
			load_seen <= next_load_seen;
		end
	end

	assign o_busy        = (pstate == PR_BUSY);
	assign o_print_start = (pstate == PR_IDLE) && start;
	assign o_selected    = selected;

	// ****************************************
	// Assertions
	// ****************************************
	property p_clear;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		do_clear |=> (word == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not zero register");

	property p_load;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(do_load && !do_clear) |=> (word == ($past(word) | $past(bus_in)));
	endproperty
	a_load: assert property (p_load) else $error("load did not copy busbars");

	property p_hold;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(!do_load && !do_clear) |=> $stable(word);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without strobe");

	property p_drive;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_strobes.out_gate_strobe |-> (o_drive_n == ~word);
	endproperty
	a_drive: assert property (p_drive) else $error("output busbars not showing word");

	property p_invert;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |-> (o_bus_in == ~i_bus_out_n);
	endproperty
	a_invert: assert property (p_invert) else $error("drive buffer not inverting");

	property p_busy_start;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_print_start |=> (o_busy && cnt == CNT_W'(PRINT_COUNT - 1));
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not held after load");

	// Busy may only drop once the print counter has run down
	property p_busy_run;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_busy && cnt != '0) |=> (o_busy && cnt == $past(cnt) - 1'b1);
	endproperty
	a_busy_run: assert property (p_busy_run) else $error("busy ended before print count");

	property p_busy_hold;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_busy |=> $stable(word);
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("register disturbed while busy");

	property p_unpick;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_strobes.device_unpick_strobe && in_unpick) |=> !selected;
	endproperty
	a_unpick: assert property (p_unpick) else $error("unpick did not clear selection");

	property p_sel_gate;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!selected |=> $stable(word);
	endproperty
	a_sel_gate: assert property (p_sel_gate) else $error("unselected device changed");

	c_select: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) $rose(selected));
	c_load:   cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) do_load);
	c_busy:   cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) $fell(o_busy));
	c_drive:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) i_strobes.out_gate_strobe && word != '0);
endmodule

// ==== verif/ctrl_model.sv ====
/*
 Controller and accumulator model: drives the strobes and the accumulator's
 active-low busbar drive. Assumes the bench calls one task at a time and that
 a released busbar is pulled up to all ones.
*/
module ctrl_model
	import busbar_pkg::*;
(
	input  wire logic            i_sys_clk,
	output busbar_pkg::strobes_t o_strobes,
	output logic [WORD_BITS-1:0] o_acc_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_strobes = '0;
		o_acc_n   = '1;
	end
	// Flags f: clear, load, gate, unpick, pick
	task automatic step(input logic [2:0] per, input logic [4:0] f, input logic [WORD_BITS-1:0] acc,
		input logic on);
		@(negedge i_sys_clk);
		o_strobes <= strobes_t'({f, per});
		o_acc_n   <= on ? ~acc : '1;
	endtask
	task automatic sel(input logic [WORD_BITS-1:0] addr);
		step(3'h0, 5'h02, '0, 1'b0);
		step(3'h1, 5'h02, '0, 1'b0);
		step(3'h3, 5'h01, addr, 1'b1);
		step(3'h0, 5'h00, '0, 1'b0);
	endtask
	// Clear lasts one cycle only, then load alone with the accumulator driving
	task automatic xfer(input logic [WORD_BITS-1:0] d);
		step(3'h4, 5'h10, '0, 1'b0);
		step(3'h5, 5'h08, d, 1'b1);
		step(3'h0, 5'h00, '0, 1'b0);
	endtask
endmodule

// ==== verif/tb.sv ====
/*
 Self-checking bench for the printer-drive module register.
 Assumes a short print count; expected characters queue up per transfer.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import busbar_pkg::*;
	localparam int PC = 20;
	localparam logic [17:0] DEV = 18'h00003;
	logic                 i_sys_clk;
	logic                 i_rst_n;
	strobes_t             strobes;
	logic [WORD_BITS-1:0] acc_n, bus_n, bus_in, drive_n, chr, d, held;
	logic                 sel, busy, pstart;
	int                   errors, num_checks, n;
	logic [WORD_BITS-1:0] exp_q[$];

	// Wired busbars: a low driver wins
	assign bus_n = acc_n & drive_n;
	ctrl_model u_ctrl (.i_sys_clk(i_sys_clk), .o_strobes(strobes), .o_acc_n(acc_n));
	busbar_module_register #(.PRINT_COUNT(PC), .DEVICE_ADDR(DEV)) u_dut (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_strobes(strobes), .i_bus_out_n(bus_n),
		.o_bus_in(bus_in), .o_drive_n(drive_n), .o_selected(sel), .o_busy(busy),
		.o_print_start(pstart), .o_char(chr));

	initial
	begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end

	task automatic chk(input logic [WORD_BITS-1:0] got, input logic [WORD_BITS-1:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Busy must rise, then stand for the print count less the negedges already gone
	task automatic wait_print(input int gone);
		n = 0;
		while (busy !== 1'b1 && n < 10)
		begin
			@(negedge i_sys_clk);
			n++;
		end
		n = 0;
		while (busy === 1'b1 && n < 100)
		begin
			n++;
			@(negedge i_sys_clk);
		end
		chk(18'(n), 18'(PC - gone));
	endtask

	// ****************************************
	// Result watcher
	// ****************************************
	// Print start stands from the falling edge to the next rising edge only
	always @(posedge i_sys_clk)
		if (pstart === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				errors++;
				$display("unexpected at %0t: got %h expected %h", $time, chr, 18'h0);
			end
			else
				chk(chr, exp_q.pop_front());
		end

	initial
	begin
		#100000;
		errors++;
		print_verdict();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		errors = 0;
		num_checks = 0;
		i_rst_n = 1'b0;
		d = 18'($urandom(18337));
		repeat (3) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_rst_n = 1'b1;
		chk(chr, 18'h0);
		for (int i = 0; i < 3; i++)
		begin
			d = 18'($urandom);
			exp_q.push_back(d);
			u_ctrl.sel(DEV);
			chk(18'(sel), 18'h1);
			u_ctrl.xfer(d);
			wait_print(0);
		end
		$display("test transfer done");
		held = chr;
		exp_q.push_back(held);
		u_ctrl.xfer(held);
		for (int i = 0; i < 6; i++)
			u_ctrl.step(3'h5, 5'h08, 18'($urandom), 1'b1);
		u_ctrl.step(3'h0, 5'h00, '0, 1'b0);
		chk(chr, held);
		wait_print(6);
		$display("test busy done");
		u_ctrl.step(3'h2, 5'h04, '0, 1'b0);
		#1;
		chk(drive_n, ~held);
		chk(bus_in, held);
		u_ctrl.step(3'h0, 5'h00, '0, 1'b0);
		#1;
		chk(drive_n, 18'h3ffff);
		$display("test gate done");
		u_ctrl.sel(DEV + 18'h1);
		chk(18'(sel), 18'h0);
		u_ctrl.xfer(~held);
		chk(chr, held);
		u_ctrl.sel(DEV);
		u_ctrl.step(3'h2, 5'h18, ~held, 1'b1);
		u_ctrl.step(3'h0, 5'h00, '0, 1'b0);
		chk(chr, held);
		$display("test select done");
		chk(18'(exp_q.size()), 18'h0);
		print_verdict();
	end
endmodule
